/* File: rtl/qrx_config_latches.sv */
// four-channel receiver configuration latch bank, top level
//
// Function
// - power-enable latch resets 0; 0 powers receiver down, 1 enables it.
// - test-mode field resets 11; 01 video reception, 10 pattern checking.
// - secondary driver enable resets 0; 1 enables driver, 0 powers down.
// - primary driver enable resets 0; 1 enables driver, 0 powers down.
// - both drivers disabled powers down the channel output logic.
// - device reset sampled low disables every driver on all channels.
// - per-channel participation bit resets 1; 0 blocks global writes.
// - global force bit set updates all target banks regardless.
// - first static bank: bit1 clock rate, bit0 participation, resets BF.
// - second static bank: thresholds, training multiplier, participation, resets AD.
// - dynamic bank: test mode 7/5, power 6, drivers 3/2, resets B3.
// - address D is global second static copy, bit0 force, no reset.
// - address E held with strobe high drives dynamic banks continuously.
`timescale 1ns/1ps
module qrx_config_latches (
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        device_reset_n_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic [7:0]  data_in,
	input  wire logic        latch_write_strobe_in,
	output logic      [3:0]  rx_channel_power_enable_out,
	output logic      [7:0]  rx_test_mode_select_out,
	output logic      [3:0]  primary_out_driver_enable_out,
	output logic      [3:0]  secondary_out_driver_enable_out,
	output logic      [3:0]  channel_output_logic_enable_out,
	output logic      [3:0]  recovered_clock_rate_select_out,
	output logic      [3:0]  training_clock_multiplier_out,
	output logic      [7:0]  primary_detect_threshold_out,
	output logic      [7:0]  secondary_detect_threshold_out,
	output logic      [11:0] global_participate_out,
	output logic      [7:0]  write_mask_out
);
	localparam int NCH  = qrx_cfg_pkg::NUM_CH;
	localparam int NBK  = qrx_cfg_pkg::BANKS_PER_CH;
	localparam int NLAT = NCH * NBK;

	// all registered state of the top level
	typedef struct packed {
		logic [3:0]  power;
		logic [7:0]  test_mode;
		logic [3:0]  pri_drv;
		logic [3:0]  sec_drv;
		logic [3:0]  out_logic;
		logic [3:0]  clk_rate;
		logic [3:0]  train_mult;
		logic [7:0]  pri_thr;
		logic [7:0]  sec_thr;
		logic [11:0] participate;
		logic [7:0]  mask;
	} qrx_top_state_t;

	qrx_top_state_t state_reg;
	qrx_top_state_t state_next;

	logic       dev_reset;          // device reset sampled low this edge
	logic       wr_any;             // strobe qualified write
	logic       force_bit;          // force bit of the global data
	logic [7:0] bank_img [NLAT];    // images of the twelve channel banks

	// true for the three broadcast addresses
	function automatic logic qrx_is_global(input logic [3:0] a);
		qrx_is_global = (a == qrx_cfg_pkg::ADDR_GLOBAL_STATIC_RATE) ||
			(a == qrx_cfg_pkg::ADDR_GLOBAL_STATIC_DETECT) ||
			(a == qrx_cfg_pkg::ADDR_GLOBAL_DYNAMIC_CTRL);
	endfunction : qrx_is_global

	// bank kind that a global address targets
	function automatic logic [3:0] qrx_global_kind(input logic [3:0] a);
		qrx_global_kind = a - qrx_cfg_pkg::ADDR_GLOBAL_STATIC_RATE;
	endfunction : qrx_global_kind

	// reset value of a bank kind
	function automatic logic [7:0] qrx_kind_reset(input int k);
		case (k)
			qrx_cfg_pkg::KIND_STATIC_RATE: begin
				qrx_kind_reset = qrx_cfg_pkg::RST_STATIC_RATE;
			end
			qrx_cfg_pkg::KIND_STATIC_DETECT: begin
				qrx_kind_reset = qrx_cfg_pkg::RST_STATIC_DETECT;
			end
			default: begin
				qrx_kind_reset = qrx_cfg_pkg::RST_DYNAMIC_CTRL;
			end
		endcase
	endfunction : qrx_kind_reset

	// write qualification
	assign dev_reset = !device_reset_n_in;
	assign wr_any    = latch_write_strobe_in && !dev_reset;
	assign force_bit = data_in[qrx_cfg_pkg::BIT_FORCE];

	// twelve channel banks, address = channel * 3 + kind
	for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
		for (genvar k = 0; k < NBK; k++) begin : g_kind
			localparam logic [3:0] MY_ADDR = 4'(ch * NBK + k);
			localparam logic [3:0] MY_KIND = 4'(k);
			logic local_wr;
			logic global_wr;

			assign local_wr  = wr_any && (addr_in == MY_ADDR);
			assign global_wr = wr_any && qrx_is_global(addr_in) &&
				(qrx_global_kind(addr_in) == MY_KIND);

			qrx_latch_bank #(
				.RESET_VAL (qrx_kind_reset(k))
			) u_bank (
				.clk_in       (clk_in),
				.arst_n_in    (arst_n_in),
				.dev_reset_in (dev_reset),
				.local_wr_in  (local_wr),
				.global_wr_in (global_wr),
				.force_in     (force_bit),
				.data_in      (data_in),
				.bank_out     (bank_img[ch * NBK + k])
			);
		end
	end

	// decode banks into registered control outputs
	always_comb begin
		logic [7:0] s_rate;
		logic [7:0] s_det;
		logic [7:0] dyn;
		s_rate = '0;
		s_det  = '0;
		dyn    = '0;
		state_next = state_reg;
		for (int ch = 0; ch < NCH; ch++) begin
			s_rate = bank_img[ch * NBK + qrx_cfg_pkg::KIND_STATIC_RATE];
			s_det  = bank_img[ch * NBK + qrx_cfg_pkg::KIND_STATIC_DETECT];
			dyn    = bank_img[ch * NBK + qrx_cfg_pkg::KIND_DYNAMIC_CTRL];
			state_next.clk_rate[ch] = s_rate[qrx_cfg_pkg::BIT_CLOCK_RATE];
			state_next.train_mult[ch] = s_det[qrx_cfg_pkg::BIT_TRAIN_MULT];
			state_next.pri_thr[2*ch +: 2] = s_det[qrx_cfg_pkg::POS_PRI_THR_LO +: 2];
			state_next.sec_thr[2*ch +: 2] = s_det[qrx_cfg_pkg::POS_SEC_THR_LO +: 2];
			state_next.power[ch] = dyn[qrx_cfg_pkg::BIT_POWER];
			state_next.test_mode[2*ch +: 2] = {dyn[qrx_cfg_pkg::BIT_TEST_HI],
				dyn[qrx_cfg_pkg::BIT_TEST_LO]};
			state_next.pri_drv[ch] = dyn[qrx_cfg_pkg::BIT_PRI_DRV] && !dev_reset;
			state_next.sec_drv[ch] = dyn[qrx_cfg_pkg::BIT_SEC_DRV] && !dev_reset;
			state_next.out_logic[ch] = (dyn[qrx_cfg_pkg::BIT_PRI_DRV] ||
				dyn[qrx_cfg_pkg::BIT_SEC_DRV]) && !dev_reset;
			for (int k = 0; k < NBK; k++) begin
				state_next.participate[ch * NBK + k] =
					bank_img[ch * NBK + k][qrx_cfg_pkg::BIT_PARTICIPATE];
			end
		end
		// mask latch, stored only
		if (dev_reset) begin
			state_next.mask = qrx_cfg_pkg::RST_WRITE_MASK;
		end else if (wr_any && (addr_in == qrx_cfg_pkg::ADDR_WRITE_MASK)) begin
			state_next.mask = data_in;
		end
	end

	// output and mask registers
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg.power       <= '0;
			state_reg.test_mode   <= {NCH{qrx_cfg_pkg::TEST_MODE_RESET}};
			state_reg.pri_drv     <= '0;
			state_reg.sec_drv     <= '0;
			state_reg.out_logic   <= '0;
			state_reg.clk_rate    <= 4'hF;
			state_reg.train_mult  <= '0;
			state_reg.pri_thr     <= 8'hAA;
			state_reg.sec_thr     <= 8'hAA;
			state_reg.participate <= 12'hFFF;
			state_reg.mask        <= qrx_cfg_pkg::RST_WRITE_MASK;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign rx_channel_power_enable_out     = state_reg.power;
	assign rx_test_mode_select_out         = state_reg.test_mode;
	assign primary_out_driver_enable_out   = state_reg.pri_drv;
	assign secondary_out_driver_enable_out = state_reg.sec_drv;
	assign channel_output_logic_enable_out = state_reg.out_logic;
	assign recovered_clock_rate_select_out = state_reg.clk_rate;
	assign training_clock_multiplier_out   = state_reg.train_mult;
	assign primary_detect_threshold_out    = state_reg.pri_thr;
	assign secondary_detect_threshold_out  = state_reg.sec_thr;
	assign global_participate_out          = state_reg.participate;
	assign write_mask_out                  = state_reg.mask;
endmodule : qrx_config_latches

/* File: rtl/qrx_cfg_pkg.sv */
// constants for the quad receiver configuration latch bank
package qrx_cfg_pkg;
	// geometry
	localparam int NUM_CH      = 4;
	localparam int BANKS_PER_CH = 3;
	localparam int ADDR_W      = 4;
	localparam int DATA_W      = 8;

	// bank kinds within a channel
	localparam int KIND_STATIC_RATE   = 0;
	localparam int KIND_STATIC_DETECT = 1;
	localparam int KIND_DYNAMIC_CTRL  = 2;

	// address map
	localparam logic [3:0] ADDR_CHAN_A_STATIC_RATE   = 4'h0;
	localparam logic [3:0] ADDR_CHAN_A_STATIC_DETECT = 4'h1;
	localparam logic [3:0] ADDR_CHAN_A_DYNAMIC_CTRL  = 4'h2;
	localparam logic [3:0] ADDR_CHAN_B_STATIC_RATE   = 4'h3;
	localparam logic [3:0] ADDR_CHAN_B_STATIC_DETECT = 4'h4;
	localparam logic [3:0] ADDR_CHAN_B_DYNAMIC_CTRL  = 4'h5;
	localparam logic [3:0] ADDR_CHAN_C_STATIC_RATE   = 4'h6;
	localparam logic [3:0] ADDR_CHAN_C_STATIC_DETECT = 4'h7;
	localparam logic [3:0] ADDR_CHAN_C_DYNAMIC_CTRL  = 4'h8;
	localparam logic [3:0] ADDR_CHAN_D_STATIC_RATE   = 4'h9;
	localparam logic [3:0] ADDR_CHAN_D_STATIC_DETECT = 4'hA;
	localparam logic [3:0] ADDR_CHAN_D_DYNAMIC_CTRL  = 4'hB;
	localparam logic [3:0] ADDR_GLOBAL_STATIC_RATE   = 4'hC;
	localparam logic [3:0] ADDR_GLOBAL_STATIC_DETECT = 4'hD;
	localparam logic [3:0] ADDR_GLOBAL_DYNAMIC_CTRL  = 4'hE;
	localparam logic [3:0] ADDR_WRITE_MASK           = 4'hF;

	// reset values
	localparam logic [7:0] RST_STATIC_RATE   = 8'hBF;
	localparam logic [7:0] RST_STATIC_DETECT = 8'hAD;
	localparam logic [7:0] RST_DYNAMIC_CTRL  = 8'hB3;
	localparam logic [7:0] RST_WRITE_MASK    = 8'hFF;

	// field positions, common
	localparam int BIT_PARTICIPATE = 0;  // per-channel banks
	localparam int BIT_FORCE       = 0;  // global banks
	// first static bank
	localparam int BIT_CLOCK_RATE  = 1;
	// second static bank
	localparam int BIT_TRAIN_MULT  = 1;
	localparam int POS_PRI_THR_LO  = 4;
	localparam int POS_SEC_THR_LO  = 6;
	// dynamic bank
	localparam int BIT_PRI_DRV     = 2;
	localparam int BIT_SEC_DRV     = 3;
	localparam int BIT_TEST_LO     = 5;
	localparam int BIT_POWER       = 6;
	localparam int BIT_TEST_HI     = 7;

	// test mode codes
	localparam logic [1:0] TEST_MODE_VIDEO   = 2'h1;
	localparam logic [1:0] TEST_MODE_PATTERN = 2'h2;
	localparam logic [1:0] TEST_MODE_RESET   = 2'h3;
endpackage : qrx_cfg_pkg

/* File: rtl/qrx_latch_bank.sv */
// one 8-bit configuration latch bank with local and global write paths
`timescale 1ns/1ps
module qrx_latch_bank #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       dev_reset_in,
	input  wire logic       local_wr_in,
	input  wire logic       global_wr_in,
	input  wire logic       force_in,
	input  wire logic [7:0] data_in,
	output logic      [7:0] bank_out
);
	typedef struct packed {
		logic [7:0] bank;
	} qrx_bank_state_t;

	qrx_bank_state_t state_reg;
	qrx_bank_state_t state_next;

	// next bank contents
	always_comb begin
		state_next = state_reg;
		if (dev_reset_in) begin
			state_next.bank = RESET_VAL;
		end else if (local_wr_in) begin
			state_next.bank = data_in;
		end else if (global_wr_in &&
			(state_reg.bank[qrx_cfg_pkg::BIT_PARTICIPATE] || force_in)) begin
			state_next.bank = data_in;
			state_next.bank[qrx_cfg_pkg::BIT_PARTICIPATE] =
				state_reg.bank[qrx_cfg_pkg::BIT_PARTICIPATE]; // keep own bit
		end
	end

	// bank storage
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg.bank <= RESET_VAL;
		end else begin
			state_reg <= state_next;
		end
	end

	assign bank_out = state_reg.bank;
endmodule : qrx_latch_bank

/* File: bench/qrx_config_latches_props.sv */
// concurrent checks on the latch bank ports
`timescale 1ns/1ps
module qrx_config_latches_props (
	input wire logic        clk_in,
	input wire logic        arst_n_in,
	input wire logic        device_reset_n_in,
	input wire logic [3:0]  addr_in,
	input wire logic [7:0]  data_in,
	input wire logic        latch_write_strobe_in,
	input wire logic [3:0]  rx_channel_power_enable_out,
	input wire logic [7:0]  rx_test_mode_select_out,
	input wire logic [3:0]  primary_out_driver_enable_out,
	input wire logic [3:0]  secondary_out_driver_enable_out,
	input wire logic [3:0]  channel_output_logic_enable_out,
	input wire logic [3:0]  recovered_clock_rate_select_out,
	input wire logic [3:0]  training_clock_multiplier_out,
	input wire logic [7:0]  primary_detect_threshold_out,
	input wire logic [7:0]  secondary_detect_threshold_out,
	input wire logic [11:0] global_participate_out,
	input wire logic [7:0]  write_mask_out
);
	logic [7:0] d1_reg;
	logic [7:0] d2_reg;
	logic       wr;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// write taken this edge
	assign wr = latch_write_strobe_in && device_reset_n_in;
	// data two edges back
	always_ff @(posedge clk_in) begin
		d1_reg <= data_in;
		d2_reg <= d1_reg;
	end
	AST_DRV_RST:
		assert property (!device_reset_n_in |=> (primary_out_driver_enable_out
			| secondary_out_driver_enable_out) == 4'h0) else $error("driver on in reset");
	AST_OUT_LOGIC:
		assert property (channel_output_logic_enable_out == (primary_out_driver_enable_out
			| secondary_out_driver_enable_out)) else $error("output logic mismatch");
	AST_DYN_LOCAL:
		assert property (wr && addr_in == 4'h2 ##1 device_reset_n_in |=>
			{rx_channel_power_enable_out[0], rx_test_mode_select_out[1:0],
			secondary_out_driver_enable_out[0], primary_out_driver_enable_out[0]} ==
			{d2_reg[6], d2_reg[7], d2_reg[5], d2_reg[3:2]}) else $error("dynamic bank");
	AST_RATE_LOCAL:
		assert property (wr && addr_in == 4'h0 ##1 device_reset_n_in |=>
			{recovered_clock_rate_select_out[0], global_participate_out[0]} ==
			d2_reg[1:0]) else $error("rate bank");
	AST_DET_LOCAL:
		assert property (wr && addr_in == 4'h1 ##1 device_reset_n_in |=>
			{secondary_detect_threshold_out[1:0], primary_detect_threshold_out[1:0],
			training_clock_multiplier_out[0], global_participate_out[1]} ==
			{d2_reg[7:4], d2_reg[1:0]}) else $error("detect bank");
	AST_MASK:
		assert property (wr && addr_in == 4'hF ##1 device_reset_n_in |=>
			write_mask_out == d2_reg) else $error("mask bank");
	AST_FORCE_DYN:
		assert property (wr && addr_in == 4'hE && data_in[0] ##1 device_reset_n_in |=>
			primary_out_driver_enable_out == {4{d2_reg[2]}} &&
			rx_channel_power_enable_out == {4{d2_reg[6]}}) else $error("forced global");
	AST_RST_IMG:
		assert property (!device_reset_n_in ##1 !device_reset_n_in |=>
			rx_channel_power_enable_out == 4'h0 && rx_test_mode_select_out == 8'hFF &&
			global_participate_out == 12'hFFF) else $error("reset image");
	AST_HOLD:
		assert property ((!latch_write_strobe_in && device_reset_n_in)[*2] |=>
			$stable({rx_channel_power_enable_out, recovered_clock_rate_select_out,
			write_mask_out})) else $error("value moved without write");
endmodule : qrx_config_latches_props
bind qrx_config_latches qrx_config_latches_props u_props (.*);

/* File: bench/qrx_host_model.sv */
// host driving the latch write port
`timescale 1ns/1ps
module qrx_host_model (
	input  wire logic       clk_in,
	output logic      [3:0] addr_out,
	output logic      [7:0] data_out,
	output logic            strobe_out
);
	initial begin
		addr_out = 4'h0;
		data_out = 8'h00;
		strobe_out = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		addr_out = a;
		data_out = d;
		strobe_out = 1'b1;
		@(posedge clk_in);
		#1;
		strobe_out = 1'b0;
		addr_out = ~a;
		data_out = ~d;
	endtask : wr
endmodule : qrx_host_model

/* File: bench/qrx_config_latches_test.sv */
// self-checking bench for the latch bank
`timescale 1ns/1ps
module qrx_config_latches_test;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        dev_n = 1'b0;
	logic [3:0]  addr, pwr, pri, sec, olog, rate, trn;
	logic [7:0]  data, tst, pthr, sthr, mask;
	logic        stb;
	logic [11:0] part;
	int          error_cnt = 0;
	int          compares = 0;
	int          cycles = 0;
	always #2.5 clk = ~clk;
	qrx_host_model host (.clk_in(clk), .addr_out(addr), .data_out(data), .strobe_out(stb));
	qrx_config_latches dut (.clk_in(clk), .arst_n_in(arst_n), .device_reset_n_in(dev_n),
		.addr_in(addr), .data_in(data), .latch_write_strobe_in(stb),
		.rx_channel_power_enable_out(pwr), .rx_test_mode_select_out(tst),
		.primary_out_driver_enable_out(pri), .secondary_out_driver_enable_out(sec),
		.channel_output_logic_enable_out(olog), .recovered_clock_rate_select_out(rate),
		.training_clock_multiplier_out(trn), .primary_detect_threshold_out(pthr),
		.secondary_detect_threshold_out(sthr), .global_participate_out(part),
		.write_mask_out(mask));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		if (error_cnt == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : final_report
	task automatic step;
		@(posedge clk);
		#1;
	endtask : step
	// whole reset image
	task automatic image;
		chk({pwr, pri, sec, olog}, 16'h0000);
		chk({tst, mask}, 16'hFFFF);
		chk({sthr, pthr}, 16'hAAAA);
		chk({rate, trn}, 8'hF0);
		chk(part, 12'hFFF);
	endtask : image
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		#1;
		arst_n = 1'b1;
		dev_n = 1'b1;
		step();
		image();
		host.wr(4'h2, 8'h6D);
		host.wr(4'h5, 8'hC8);
		host.wr(4'h3, 8'h82);
		host.wr(4'h7, 8'h5E);
		step();
		chk({pwr, pri, sec, olog}, 16'h3133);
		chk(tst, 8'hF9);
		chk({rate, trn}, 8'hF4);
		chk({sthr, pthr}, 16'h9A9A);
		chk(part, 12'hF57);
		// global writes, with and without force
		host.wr(4'hC, 8'h80);
		host.wr(4'hD, 8'h11);
		host.wr(4'hE, 8'h24);
		step();
		chk({rate, trn}, 8'h20);
		chk({sthr, pthr}, 16'h0055);
		chk({pwr, pri, sec, olog}, 16'h2D2F);
		chk(tst, 8'h59);
		host.wr(4'hE, 8'h6D);
		host.wr(4'hF, 8'h3C);
		host.wr(4'h0, 8'hB2);
		host.wr(4'h1, 8'hE3);
		step();
		chk({pwr, pri, sec, olog}, 16'hFFFF);
		chk({tst, mask}, 16'h553C);
		chk({rate, trn}, 8'h31);
		chk({sthr, pthr}, 16'h0356);
		chk(part, 12'hF56);
		// write under device reset is ignored
		dev_n = 1'b0;
		host.wr(4'h2, 8'h6D);
		chk({pri, sec}, 8'h00);
		dev_n = 1'b1;
		step();
		image();
		final_report();
	end
endmodule : qrx_config_latches_test
